// ---- logic/ofl_fault_logic.sv ----
// Purpose: Fault supervision, shutdown and status word for twelve outputs.
// Assumes: Commands and configuration come from logic on clk; sensors,
//          chip select, serial clock and serial in are asynchronous pins.
// Notes:   Serial clock is sampled; data moves on its sampled edges.
`timescale 1ns/100ps
module ofl_fault_logic import ofl_pkg::*; #(
    parameter int FILT_CYCLES = FILT_CYC
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               nrst,
    // Resolved on/off commands (serial or direct input)
    input  wire logic [OUT_N-1:0]   output_cmd_on,
    // Configuration
    input  wire logic [OUT_N-1:0]   open_load_enable_config,
    input  wire logic [LS_N-1:0]    overcurrent_shutdown_config,
    // Sensor comparators
    input  wire logic               battery_overvoltage,
    input  wire logic [OUT_N-1:0]   overtemp_sense,
    input  wire logic [OUT_N-1:0]   open_load_sense,
    input  wire logic [LS_N-1:0]    ls_drain_high,
    input  wire logic [HS_N-1:0]    hs_gate_low,
    // Serial port
    input  wire logic               spi_cs_n,
    input  wire logic               spi_sclk,
    input  wire logic               spi_si,
    input  wire logic [UPPER_W-1:0] status_upper_bits,
    output logic                    spi_so,
    output logic                    spi_so_oe,
    // Outputs and fault indication
    output logic [OUT_N-1:0]        output_gate_on,
    output logic [LS_N-1:0]         lowside_current_limit,
    output logic [OUT_N-1:0]        output_fault_status_bits,
    output logic                    fault_indicator_pin_n
);
    typedef struct packed {
        logic [SY_W-1:0]   s1;
        logic [SY_W-1:0]   s2;
        logic [SY_W-1:0]   s3;
        logic [SY_W-1:0]   st;
        logic              cs_prev;
        logic              sclk_prev;
        logic [OUT_N-1:0]  cmd_prev;
        logic [LS_N-1:0]   ot_lock;
        logic [LS_N-1:0]   oc_lock;
        logic [LS_N-1:0]   fs_latch;
        logic [OUT_N-1:0]  stat;
        logic [OUT_N-1:0]  gate;
        logic [LS_N-1:0]   climit;
        logic              fs_n;
        ofl_xfer_e         xfer;
        logic              si_bit;
        logic [WORD_W-1:0] shift;
    } ofl_state_s;

    localparam ofl_state_s STATE_RST = '{
        s1: SYNC_RST, s2: SYNC_RST, s3: SYNC_RST, st: SYNC_RST,
        cs_prev: 1'b1, sclk_prev: 1'b0, cmd_prev: '0,
        ot_lock: '0, oc_lock: '0, fs_latch: '0,
        stat: STAT_RST, gate: '0, climit: '0, fs_n: 1'b1,
        xfer: ofl_idle, si_bit: 1'b0, shift: SHIFT_RST
    };

    ofl_state_s r, nxt;

    logic [SY_W-1:0]  async_vec;
    logic             cs_n;
    logic             sclk;
    logic             ov;
    logic [OUT_N-1:0] ot;
    logic [OUT_N-1:0] ol;
    logic [LS_N-1:0]  drain;
    logic [HS_N-1:0]  gate_low;
    logic [OUT_N-1:0] cmd_tog;
    logic [OUT_N-1:0] ot_cond;
    logic [HS_N-1:0]  hs_ol;
    logic [LS_N-1:0]  ls_cmd;
    logic [LS_N-1:0]  ls_ol_arm;
    logic [LS_N-1:0]  ls_oc_arm;
    logic [LS_N-1:0]  ls_ol_hit;
    logic [LS_N-1:0]  ls_oc_hit;
    logic [LS_N-1:0]  ls_ot;
    logic [LS_N-1:0]  ls_gate;
    logic [HS_N-1:0]  hs_gate;
    logic [OUT_N-1:0] cause;
    logic [OUT_N-1:0] stat_clr;
    logic             cs_rise;
    logic             cs_fall;
    logic             sclk_rise;
    logic             sclk_fall;

    assign async_vec = {hs_gate_low, ls_drain_high, open_load_sense,
                        overtemp_sense, battery_overvoltage, spi_si,
                        spi_sclk, spi_cs_n};

    // Only the stable word is read; raw stages feed the next stage alone
    assign cs_n     = r.st[SY_CS];
    assign sclk     = r.st[SY_SCLK];
    assign ov       = r.st[SY_OV];
    assign ot       = r.st[SY_OT +: OUT_N];
    assign ol       = r.st[SY_OL +: OUT_N];
    assign drain    = r.st[SY_DR +: LS_N];
    assign gate_low = r.st[SY_GL +: HS_N];

    assign ls_cmd    = output_cmd_on[LS_BASE +: LS_N];
    // Open load only while commanded off, low-side enabled by a one
    assign ls_ol_arm = ~ls_cmd
                     & open_load_enable_config[LS_BASE +: LS_N];
    // Timer only runs while the output really conducts and shutdown is on
    assign ls_oc_arm = r.gate[LS_BASE +: LS_N]
                     & overcurrent_shutdown_config;

    genvar g;
    generate
        for (g = 0; g < LS_N; g++) begin : g_ls
            ofl_filter #(
                .CYCLES (FILT_CYCLES)
            ) u_ol_filt (
                .clk  (clk),
                .nrst (nrst),
                .arm  (ls_ol_arm[g]),
                .raw  (ol[LS_BASE + g]),
                .hit  (ls_ol_hit[g])
            );
            ofl_filter #(
                .CYCLES (FILT_CYCLES)
            ) u_oc_filt (
                .clk  (clk),
                .nrst (nrst),
                .arm  (ls_oc_arm[g]),
                .raw  (drain[g]),
                .hit  (ls_oc_hit[g])
            );
        end
    endgenerate

    always_comb begin
        nxt = r;

        // Three-stage synchroniser; a bit changes once stages 2 and 3 agree
        nxt.s1 = async_vec;
        nxt.s2 = r.s1;
        nxt.s3 = r.s2;
        nxt.st = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.st);

        nxt.cs_prev   = cs_n;
        nxt.sclk_prev = sclk;
        cs_rise   = cs_n & ~r.cs_prev;
        cs_fall   = ~cs_n & r.cs_prev;
        sclk_rise = sclk & ~r.sclk_prev;
        sclk_fall = ~sclk & r.sclk_prev;

        cmd_tog      = output_cmd_on ^ r.cmd_prev;
        nxt.cmd_prev = output_cmd_on;

        // Temperature is only meaningful while the output is commanded on
        ot_cond = ot & output_cmd_on;
        ls_ot   = ot_cond[LS_BASE +: LS_N];

        // High-side open load: enabled by zero, off, gate already low
        hs_ol = ~output_cmd_on[HS_N-1:0]
              & ~open_load_enable_config[HS_N-1:0]
              & gate_low & ol[HS_N-1:0];

        // Low-side thermal latch-off, released by an off command whatever the temperature
        nxt.ot_lock = (r.ot_lock & ~(~ls_ot & ~ls_cmd)) | ls_ot;

        // Overcurrent latch-off; the only way out is commanding off
        nxt.oc_lock = (r.oc_lock & ls_cmd) | ls_oc_hit;

        // High side cycles with temperature on its own
        hs_gate = output_cmd_on[HS_N-1:0]
                & ~ot_cond[HS_N-1:0]
                & {HS_N{~ov}};
        ls_gate = ls_cmd & ~ls_ot & ~r.ot_lock & ~r.oc_lock
                & ~ls_oc_hit & {LS_N{~ov}};
        nxt.gate = {ls_gate, hs_gate};

        // Without shutdown the driver limits current and reports nothing
        nxt.climit = ls_gate & drain & ~overcurrent_shutdown_config;

        // Present cause per output; overvoltage counts on all of them
        cause[HS_N-1:0] = ot_cond[HS_N-1:0] | hs_ol
                        | {HS_N{ov}};
        cause[LS_BASE +: LS_N] = ls_ot | ls_ol_hit | ls_oc_hit
                               | r.oc_lock | {LS_N{ov}};

        // A new cause in the clearing cycle keeps its bit set
        stat_clr = cs_rise ? ~cause : '0;
        nxt.stat = (r.stat & ~stat_clr) | cause;

        // Low-side pin latch; a toggle of the faulted output releases it
        nxt.fs_latch = (r.fs_latch & ~cmd_tog[LS_BASE +: LS_N])
                     | ls_ot | ls_ol_hit | ls_oc_hit;
        nxt.fs_n = ~(ov | (|ot_cond[HS_N-1:0]) | (|hs_ol)
                 | (|nxt.fs_latch));

        // Serial status transfer
        unique case (r.xfer)
            ofl_idle: begin
                if (cs_fall) begin
                    nxt.xfer  = ofl_xfer;
                    nxt.shift = {status_upper_bits, r.stat};
                end
            end
            ofl_xfer: begin
                if (cs_rise) begin
                    nxt.xfer = ofl_idle;
                end else if (sclk_rise) begin
                    nxt.si_bit = r.st[SY_SI];
                end else if (sclk_fall) begin
                    // Trailing bits echo serial in for daisy chains
                    nxt.shift = {r.shift[WORD_W-2:0], r.si_bit};
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= STATE_RST;
        end else begin
            r <= nxt;
        end
    end

    assign spi_so                   = r.shift[WORD_W-1];
    assign spi_so_oe                = (r.xfer == ofl_xfer);
    assign output_gate_on           = r.gate;
    assign lowside_current_limit    = r.climit;
    assign output_fault_status_bits = r.stat;
    assign fault_indicator_pin_n    = r.fs_n;
endmodule : ofl_fault_logic

// ---- logic/ofl_filter.sv ----
// Purpose: Fault filter; a fault is taken once it stands for a full delay.
// Assumes: raw is already synchronised to clk.
// Notes:   Count restarts whenever arm or raw drops.
`timescale 1ns/100ps
module ofl_filter import ofl_pkg::*; #(
    parameter int CYCLES = FILT_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Detection
    input  wire logic arm,
    input  wire logic raw,
    output logic      hit
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] TOP = CW'(CYCLES);

    typedef struct packed {
        logic [CW-1:0] cnt;
    } ofl_flt_s;

    ofl_flt_s r, nxt;

    always_comb begin
        nxt = r;
        if (!(arm && raw)) begin
            nxt.cnt = '0;
        end else if (r.cnt != TOP) begin
            nxt.cnt = r.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign hit = arm && raw && (r.cnt == TOP);
endmodule : ofl_filter

// ---- shared/ofl_pkg.sv ----
// Purpose: Shared constants for the output fault latch block.
// Assumes: 25 MHz core clock, four high-side and eight low-side outputs.
// Notes:   Sync vector positions pack every asynchronous input in one word.
package ofl_pkg;
    localparam int OUT_N    = 12;
    localparam int HS_N     = 4;
    localparam int LS_N     = 8;
    localparam int LS_BASE  = 4;
    localparam int WORD_W   = 16;
    localparam int UPPER_W  = 4;

    // Timing
    localparam int CLK_KHZ      = 25000;
    localparam int FILT_DLY_NS  = 10000;
    localparam int FILT_CYC     = (FILT_DLY_NS * CLK_KHZ + 999999) / 1000000;

    // Positions in the synchroniser vector
    localparam int SY_CS   = 0;
    localparam int SY_SCLK = 1;
    localparam int SY_SI   = 2;
    localparam int SY_OV   = 3;
    localparam int SY_OT   = 4;
    localparam int SY_OL   = 16;
    localparam int SY_DR   = 28;
    localparam int SY_GL   = 36;
    localparam int SY_W    = 40;

    // Reset values
    localparam logic [OUT_N-1:0]  STAT_RST  = 12'h000;
    localparam logic [WORD_W-1:0] SHIFT_RST = 16'h0000;
    localparam logic [SY_W-1:0]   SYNC_RST  = 40'h00_0000_0001;

    typedef enum logic [0:0] {
        ofl_idle = 1'b0,
        ofl_xfer = 1'b1
    } ofl_xfer_e;
endpackage : ofl_pkg

// ---- sim/ofl_fault_logic_asserts.sv ----
// Purpose: Port-level checks on the output fault latch block.
// Assumes: Pins reach the logic four to five clocks after they move.
// Notes:   Windows are sized for a filter of four clocks.
`timescale 1ns/100ps
module ofl_fault_logic_asserts import ofl_pkg::*; #(
    parameter int FILT_CYCLES = FILT_CYC
) (
    // Clock and reset
    input wire logic             clk,
    input wire logic             nrst,
    // Inputs
    input wire logic [OUT_N-1:0] output_cmd_on,
    input wire logic [OUT_N-1:0] open_load_enable_config,
    input wire logic [LS_N-1:0]  overcurrent_shutdown_config,
    input wire logic             battery_overvoltage,
    input wire logic [OUT_N-1:0] overtemp_sense,
    input wire logic [OUT_N-1:0] open_load_sense,
    input wire logic [LS_N-1:0]  ls_drain_high,
    input wire logic [HS_N-1:0]  hs_gate_low,
    input wire logic             spi_cs_n,
    // Outputs
    input wire logic             spi_so_oe,
    input wire logic [OUT_N-1:0] output_gate_on,
    input wire logic [LS_N-1:0]  lowside_current_limit,
    input wire logic [OUT_N-1:0] output_fault_status_bits,
    input wire logic             fault_indicator_pin_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_oc;
        ls_drain_high[0] && overcurrent_shutdown_config[0] && output_cmd_on[4];
    endsequence
    property p_ov;
        battery_overvoltage [*7] |-> output_gate_on == 12'h000 &&
            output_fault_status_bits == 12'hfff && !fault_indicator_pin_n;
    endproperty
    a_ov: assert property (p_ov) else $error("overvoltage");
    property p_gate;
        (output_gate_on & ~$past(output_cmd_on)) == 12'h000;
    endproperty
    a_gate: assert property (p_gate) else $error("gate");
    // Seven quiet clocks mean no chip-select rise can still be in flight
    property p_hold;
        $stable(spi_cs_n) [*7] |-> (output_fault_status_bits &
            $past(output_fault_status_bits)) == $past(output_fault_status_bits);
    endproperty
    a_hold: assert property (p_hold) else $error("clear");
    property p_oe_on;
        $fell(spi_cs_n) |-> ##[2:6] spi_so_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("oe on");
    property p_oe_off;
        $rose(spi_cs_n) |-> ##[2:6] !spi_so_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("oe off");
    property p_cl;
        (lowside_current_limit & $past(overcurrent_shutdown_config)) == 8'h00;
    endproperty
    a_cl: assert property (p_cl) else $error("limit");
    property p_oc;
        s_oc [*8] ##1 s_oc [*8] |->
            !output_gate_on[4] && output_fault_status_bits[4];
    endproperty
    a_oc: assert property (p_oc) else $error("overcurrent");
    property p_hot;
        (overtemp_sense[0] && output_cmd_on[0]) [*7] |-> !output_gate_on[0]
            && output_fault_status_bits[0] && !fault_indicator_pin_n;
    endproperty
    a_hot: assert property (p_hot) else $error("hs temp");
    property p_hol;
        (open_load_sense[1] && !output_cmd_on[1] && hs_gate_low[1] &&
            !open_load_enable_config[1]) [*7] |->
            output_fault_status_bits[1] && !fault_indicator_pin_n;
    endproperty
    a_hol: assert property (p_hol) else $error("hs open");
    c_ov: cover property (battery_overvoltage [*7]);
    c_oc: cover property (s_oc [*8]);
    c_xfer: cover property ($rose(spi_so_oe));
endmodule : ofl_fault_logic_asserts

bind ofl_fault_logic ofl_fault_logic_asserts #(.FILT_CYCLES(FILT_CYCLES))
    ofl_chk_inst (.clk(clk), .nrst(nrst), .output_cmd_on(output_cmd_on),
    .open_load_enable_config(open_load_enable_config),
    .overcurrent_shutdown_config(overcurrent_shutdown_config),
    .battery_overvoltage(battery_overvoltage),
    .overtemp_sense(overtemp_sense), .open_load_sense(open_load_sense),
    .ls_drain_high(ls_drain_high), .hs_gate_low(hs_gate_low),
    .spi_cs_n(spi_cs_n), .spi_so_oe(spi_so_oe),
    .output_gate_on(output_gate_on),
    .lowside_current_limit(lowside_current_limit),
    .output_fault_status_bits(output_fault_status_bits),
    .fault_indicator_pin_n(fault_indicator_pin_n));

// ---- sim/ofl_host_model.sv ----
// Purpose: Host end of the serial port; reads one status word a frame.
// Assumes: Word bits move on the falling serial clock.
// Notes:   Serial clock stands low between frames.
`timescale 1ns/100ps
module ofl_host_model (
    // Clock
    input wire logic   clk,
    // Serial port
    input wire logic   spi_so,
    output logic       spi_cs_n,
    output logic       spi_sclk,
    output logic       spi_si,
    // Result
    output logic [15:0] rx_word,
    output logic       rx_done
);
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_si   = 1'b0;
        rx_word  = 16'h0000;
        rx_done  = 1'b0;
    end
    task automatic xfer();
        integer i;
        @(posedge clk);
        #1 spi_cs_n = 1'b0;
        // Let the first bit settle through the synchroniser
        repeat (8) @(posedge clk);
        // Bit taken just before the fall: the pin synchroniser holds the
        // device's shift back longer than half a serial period
        for (i = 15; i >= 0; i--) begin
            #1 spi_sclk = 1'b1;
            repeat (4) @(posedge clk);
            #1 rx_word[i] = spi_so;
            spi_sclk = 1'b0;
            spi_si = 1'($urandom);
            repeat (4) @(posedge clk);
        end
        #1 spi_cs_n = 1'b1;
        repeat (8) @(posedge clk);
        #1 rx_done = 1'b1;
        @(posedge clk);
        #1 rx_done = 1'b0;
    endtask : xfer
endmodule : ofl_host_model

// ---- sim/testbench.sv ----
// Purpose: Self-checking bench for the output fault latch block.
// Assumes: Filter shortened to four clocks.
// Notes:   Fixed waits cover the pin synchroniser latency.
`timescale 1ns/100ps
module testbench import ofl_pkg::*;;
    logic [OUT_N-1:0]   cmd, ol_cfg, ot, ol, gate, stat;
    logic [LS_N-1:0]    oc_cfg, drain, clim;
    logic [UPPER_W-1:0] up;
    logic               clk, nrst, ov, so, oe, cs_n, sclk, si, fpin_n, done;
    logic [15:0]        word;
    logic [15:0]        exp_q[$];
    int                 failures, samples_checked;
    always #20 clk = ~clk;
    ofl_fault_logic #(.FILT_CYCLES(4)) ofl_fault_logic_inst (.clk(clk),
        .nrst(nrst), .output_cmd_on(cmd), .open_load_enable_config(ol_cfg),
        .overcurrent_shutdown_config(oc_cfg), .battery_overvoltage(ov),
        .overtemp_sense(ot), .open_load_sense(ol), .ls_drain_high(drain),
        .hs_gate_low(~gate[3:0]), .spi_cs_n(cs_n), .spi_sclk(sclk),
        .spi_si(si), .status_upper_bits(up), .spi_so(so), .spi_so_oe(oe),
        .output_gate_on(gate), .lowside_current_limit(clim),
        .output_fault_status_bits(stat), .fault_indicator_pin_n(fpin_n));
    ofl_host_model ofl_host_model_inst (.clk(clk), .spi_so(so),
        .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_si(si), .rx_word(word),
        .rx_done(done));
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask : chk
    task automatic rd(logic [OUT_N-1:0] e);
        exp_q.push_back({up, e});
        ofl_host_model_inst.xfer();
    endtask : rd
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic end_of_test();
        if (failures == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test
    always @(posedge clk) begin
        if (done === 1'b1) begin
            if (exp_q.size() == 0) begin
                $display("MISMATCH word expected none seen %h", word);
                failures++;
            end else begin
                chk("word", exp_q.pop_front(), word);
            end
        end
    end
    initial begin
        repeat (60000) @(posedge clk);
        $display("MISMATCH cycles expected below %0d seen %0d", 60000, 60000);
        failures++;
        end_of_test();
    end
    initial begin
        {clk, nrst, ov, cmd, ol_cfg, ot, ol, oc_cfg, drain} = '0;
        failures = 0;
        samples_checked = 0;
        up = 4'($urandom(30));
        repeat (16) @(posedge clk);
        #1 nrst = 1'b1;
        tick(8);
        rd(12'h000);
        cmd = 12'hfff;
        ov = 1'b1;
        tick(12);
        ov = 1'b0;
        tick(8);
        chk("pin", 16'h1, 16'(fpin_n));
        rd(12'hfff);
        rd(12'h000);
        cmd = 12'h003;
        ot = 12'h001;
        tick(12);
        chk("gate", 16'h2, 16'(gate));
        ot = 12'h000;
        tick(8);
        chk("gate", 16'h3, 16'(gate));
        chk("pin", 16'h1, 16'(fpin_n));
        rd(12'h001);
        cmd = 12'h020;
        ot = 12'h020;
        tick(12);
        ot = 12'h000;
        tick(12);
        chk("gate", 16'h0, 16'(gate));
        chk("pin", 16'h0, 16'(fpin_n));
        cmd = 12'h000;
        tick(2);
        chk("pin", 16'h1, 16'(fpin_n));
        cmd = 12'h020;
        tick(2);
        chk("gate", 16'h20, 16'(gate));
        rd(12'h020);
        oc_cfg = 8'h01;
        drain = 8'h01;
        cmd = 12'h010;
        tick(20);
        chk("pin", 16'h0, 16'(fpin_n));
        cmd = 12'h000;
        tick(1);
        cmd = 12'h010;
        tick(20);
        chk("gate", 16'h0, 16'(gate));
        rd(12'h010);
        drain = 8'h00;
        cmd = 12'h000;
        tick(1);
        cmd = 12'h010;
        tick(8);
        chk("gate", 16'h10, 16'(gate));
        rd(12'h010);
        oc_cfg = 8'h00;
        drain = 8'h01;
        tick(20);
        chk("limit", 16'h1, 16'(clim));
        chk("gate", 16'h10, 16'(gate));
        drain = 8'h00;
        tick(8);
        rd(12'h000);
        cmd = 12'h000;
        ol = 12'h012;
        tick(12);
        chk("pin", 16'h0, 16'(fpin_n));
        ol = 12'h000;
        tick(8);
        chk("pin", 16'h1, 16'(fpin_n));
        rd(12'h002);
        ol_cfg = 12'h040;
        ol = 12'h040;
        tick(20);
        ol = 12'h000;
        tick(8);
        chk("pin", 16'h0, 16'(fpin_n));
        rd(12'h040);
        // Reset in mid-run must release the latched fault pin
        nrst = 1'b0;
        tick(2);
        nrst = 1'b1;
        tick(2);
        chk("pin", 16'h1, 16'(fpin_n));
        tick(4);
        if (exp_q.size() != 0) begin
            $display("MISMATCH queue expected 0 seen %0d", exp_q.size());
            failures++;
        end
        end_of_test();
    end
endmodule : testbench
